// ---- ihbs_client_model.sv ----
// Client side of the bus: pull-ups, clock stretching and a bus jam
`timescale 1ns/1ps
`default_nettype none
module ihbs_client_model
   import ihbs_pkg::*;
(
   input wire logic                   pclk,
   input wire logic                   presetn,
   input wire ihbs_pkg::ihbs_line_t   line_oe,
   input wire logic [3:0]             stretch,
   input wire logic                   jam,
   output var ihbs_pkg::ihbs_line_t   line_in
);
   logic [3:0] cnt;
   logic       prev_scl;
   logic       hold;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt      <= 4'h0;
         prev_scl <= 1'b0;
      end
      else
      begin
         prev_scl <= line_oe.scl;
         if (prev_scl && !line_oe.scl)
            cnt <= stretch;
         else if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
      end
   end
   // Keeps SCL low from the very cycle the host lets go
   assign hold = (prev_scl && !line_oe.scl && stretch != 4'h0) || cnt != 4'h0;
   assign line_in = '{sda: !(line_oe.sda || jam), scl: !(line_oe.scl || hold || jam)};
endmodule : ihbs_client_model
`default_nettype wire

// ---- ihbs_pkg.sv ----
// Package with register map, field positions and types of the I2C host sequencer
package ihbs_pkg;

   localparam int ADDR_W  = 5;
   localparam int DATA_W  = 32;
   localparam int DIV_W   = 8;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL   = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_SEQ    = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_DIV    = 5'h0c;
   localparam logic [ADDR_W-1:0] OFS_BUF    = 5'h10;

   // Control register fields
   localparam int CTRL_ENABLE    = 0;
   localparam int CTRL_MODE_LSB  = 1;
   localparam int CTRL_SW_SDA    = 3;
   localparam int CTRL_SW_SCL    = 4;

   // Mode select encodings
   localparam logic [1:0] MODE_OFF     = 2'h0;
   localparam logic [1:0] MODE_HOST    = 2'h1;
   localparam logic [1:0] MODE_FW_HOST = 2'h2;

   // Sequence control fields; the low five bits are the request field
   localparam int SEQ_START    = 0;
   localparam int SEQ_RESTART  = 1;
   localparam int SEQ_STOP     = 2;
   localparam int SEQ_ACK      = 3;
   localparam int SEQ_RSVD     = 4;
   localparam int SEQ_REQ_W    = 5;
   localparam int SEQ_ACK_VAL  = 5;

   // Status fields
   localparam int ST_START_DET = 0;
   localparam int ST_STOP_DET  = 1;
   localparam int ST_IRQ       = 2;
   localparam int ST_WRITE_COLLISION_FLAG      = 3;
   localparam int ST_BCOL      = 4;
   localparam int ST_BUSY      = 5;
   localparam int ST_BUS_CLAIM = 6;

   // Reset values
   localparam logic [DIV_W-1:0] DIV_RESET = 8'h09;
   localparam logic [7:0]       BUF_RESET = 8'h00;

   typedef struct packed {
      logic sda;
      logic scl;
   } ihbs_line_t;

   typedef enum logic [4:0] {
      S_IDLE, S_ST_A, S_ST_B,
      S_RS_A, S_RS_B, S_RS_C, S_RS_D, S_RS_E,
      S_AK_A, S_AK_B, S_AK_C,
      S_SP_A, S_SP_B, S_SP_C, S_SP_D, S_SP_E, S_SP_F
   } ihbs_state_t;

endpackage : ihbs_pkg

// ---- ihbs_properties.sv ----
// Port-level properties of the I2C host sequencer
`timescale 1ns/1ps
`default_nettype none
module ihbs_properties
   import ihbs_pkg::*;
(
   input wire logic                   pclk,
   input wire logic                   presetn,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic [ADDR_W-1:0]      paddr,
   input wire logic                   pready,
   input wire logic                   pslverr,
   input wire ihbs_pkg::ihbs_line_t   line_in,
   input wire ihbs_pkg::ihbs_line_t   line_out,
   input wire ihbs_pkg::ihbs_line_t   line_oe
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready held too long");
   ready_wait_a: assert property ($rose(penable) && psel |=> pready)
      else $error("pready late");
   ready_access_a: assert property (pready |-> psel && penable)
      else $error("pready outside access");
   unmapped_err_a: assert property (pready && (paddr[1:0] != 2'h0 || paddr > OFS_BUF) |-> pslverr)
      else $error("no error on unmapped access");
   mapped_ok_a: assert property (pready && paddr[1:0] == 2'h0 && paddr <= OFS_BUF |-> !pslverr)
      else $error("error on mapped access");
   open_drain_a: assert property (line_out == 2'h0)
      else $error("line driven high");
   stretch_hold_a: assert property ((!line_oe.scl && !line_in.scl) [*4] |=> !line_oe.scl)
      else $error("scl pulled while stretched");
   start_edge_a: assert property ($rose(line_oe.sda) && !line_oe.scl |-> line_in.scl)
      else $error("sda pulled with scl low");
endmodule : ihbs_properties
bind ihbs_sequencer ihbs_properties chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .paddr(paddr), .pready(pready), .pslverr(pslverr), .line_in(line_in), .line_out(line_out), .line_oe(line_oe));
`default_nettype wire

// ---- ihbs_sequencer.sv ----
// I2C host bus sequencer: APB registers, baud counter, start/restart/ack/stop sequencing
`timescale 1ns/1ps
`default_nettype none

module ihbs_sequencer
   import ihbs_pkg::*;
#(
   parameter int DIVW = ihbs_pkg::DIV_W
)(
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [ihbs_pkg::ADDR_W-1:0]   paddr,
   input  wire logic [ihbs_pkg::DATA_W-1:0]   pwdata,
   output var  logic [ihbs_pkg::DATA_W-1:0]   prdata,
   output var  logic                          pready,
   output var  logic                          pslverr,
   input  wire ihbs_pkg::ihbs_line_t          line_in,
   output var  ihbs_pkg::ihbs_line_t          line_out,
   output var  ihbs_pkg::ihbs_line_t          line_oe,
   output var  logic                          serial_irq_flag
);
   import ihbs_pkg::*;

   // Registers
   logic                port_enable_bit;
   logic [1:0]          port_mode_select;
   logic                sw_sda_low;
   logic                sw_scl_low;
   logic [SEQ_REQ_W-1:0] seq_req;
   logic                ack_value_bit;
   logic [DIVW-1:0]     baud_divisor_reg;
   logic [7:0]          shift_buffer;
   logic                start_detected;
   logic                stop_detected;
   logic                write_collision_flag;
   logic                bus_collision_flag;

   // Line sampling
   ihbs_line_t          sync1;
   ihbs_line_t          sync2;
   ihbs_line_t          prev;

   // Sequencer
   ihbs_state_t         state;
   ihbs_state_t         next_state;
   logic [DIVW-1:0]     baud_counter;
   logic                baud_run;
   logic                brg_load;
   logic                brg_halt;
   logic                next_sda_low;
   logic                next_scl_low;
   logic                set_start_flag;
   logic                set_stop_flag;
   logic                set_bcol;
   logic                set_irq;
   logic                req_done;
   logic                drv_sda_low;
   logic                drv_scl_low;

   logic                host_active;
   logic                fw_active;
   logic                det_en;
   logic                det_start;
   logic                det_stop;
   logic                baud_timeout;
   logic                apb_done;
   logic                wr_done;
   logic                mapped;
   logic [DATA_W-1:0]   rd_word;

   assign host_active  = port_enable_bit && (port_mode_select == MODE_HOST);
   assign fw_active    = port_enable_bit && (port_mode_select == MODE_FW_HOST);
   assign baud_timeout = baud_run && (baud_counter == '0);

   // Start/stop detection is off while the host generates its own start or stop; it stays on through a restart
   assign det_en = (fw_active || host_active) &&
                   !(state inside {S_ST_A, S_ST_B, S_SP_A, S_SP_B, S_SP_C, S_SP_D, S_SP_E, S_SP_F});
   assign det_start = det_en && prev.scl && sync2.scl && prev.sda && !sync2.sda;
   assign det_stop  = det_en && prev.scl && sync2.scl && !prev.sda && sync2.sda;

   assign apb_done = psel && penable && pready;
   assign wr_done  = apb_done && pwrite;
   assign mapped   = paddr inside {OFS_CTRL, OFS_SEQ, OFS_STATUS, OFS_DIV, OFS_BUF};

   // Two-flop synchroniser plus one history stage for edge finding
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync1 <= '{sda: 1'b1, scl: 1'b1};
         sync2 <= '{sda: 1'b1, scl: 1'b1};
         prev  <= '{sda: 1'b1, scl: 1'b1};
      end
      else
      begin
         sync1 <= line_in;
         sync2 <= sync1;
         prev  <= sync2;
      end
   end

   // Sequencer decisions
   always_comb
   begin
      next_state     = state;
      brg_load       = 1'b0;
      brg_halt       = 1'b0;
      next_sda_low   = drv_sda_low;
      next_scl_low   = drv_scl_low;
      set_start_flag = 1'b0;
      set_stop_flag  = 1'b0;
      set_bcol       = 1'b0;
      set_irq        = 1'b0;
      req_done       = 1'b0;
      case (state)
         S_IDLE:
         begin
            if (seq_req[SEQ_START])
            begin
               if (sync2.sda && sync2.scl)
               begin
                  brg_load   = 1'b1;
                  next_state = S_ST_A;
               end
               else if (!sync2.sda && !sync2.scl)
               begin
                  set_bcol = 1'b1;
                  req_done = 1'b1;
               end
            end
            else if (seq_req[SEQ_RESTART])
            begin
               next_scl_low = 1'b1;
               next_state   = S_RS_A;
            end
            else if (seq_req[SEQ_STOP])
            begin
               next_scl_low = 1'b1;
               next_sda_low = 1'b1;
               next_state   = S_SP_A;
            end
            else if (seq_req[SEQ_ACK])
            begin
               next_scl_low = 1'b1;
               next_sda_low = !ack_value_bit;
               brg_load     = 1'b1;
               next_state   = S_AK_A;
            end
         end
         S_ST_A:
         begin
            if (!sync2.scl || (baud_timeout && !sync2.sda))
            begin
               set_bcol     = 1'b1;
               req_done     = 1'b1;
               brg_halt     = 1'b1;
               next_sda_low = 1'b0;
               next_state   = S_IDLE;
            end
            else if (baud_timeout)
            begin
               next_sda_low   = 1'b1;
               set_start_flag = 1'b1;
               brg_load       = 1'b1;
               next_state     = S_ST_B;
            end
         end
         S_ST_B:
         begin
            if (baud_timeout)
            begin
               req_done   = 1'b1;
               set_irq    = 1'b1;
               brg_halt   = 1'b1;
               next_state = S_IDLE;
            end
         end
         S_RS_A:
         begin
            if (!sync2.scl)
            begin
               next_sda_low = 1'b0;
               brg_load     = 1'b1;
               next_state   = S_RS_B;
            end
         end
         S_RS_B:
         begin
            if (baud_timeout)
            begin
               brg_halt = 1'b1;
               if (sync2.sda)
               begin
                  next_scl_low = 1'b0;
                  next_state   = S_RS_C;
               end
               else
               begin
                  set_bcol   = 1'b1;
                  req_done   = 1'b1;
                  next_scl_low = 1'b0;
                  next_state = S_IDLE;
               end
            end
         end
         S_RS_C:
         begin
            if (sync2.scl)
            begin
               if (!sync2.sda)
               begin
                  set_bcol   = 1'b1;
                  req_done   = 1'b1;
                  next_state = S_IDLE;
               end
               else
               begin
                  brg_load   = 1'b1;
                  next_state = S_RS_D;
               end
            end
         end
         S_RS_D:
         begin
            if (!sync2.scl)
            begin
               set_bcol   = 1'b1;
               req_done   = 1'b1;
               brg_halt   = 1'b1;
               next_state = S_IDLE;
            end
            else if (baud_timeout)
            begin
               next_sda_low = 1'b1;
               brg_load     = 1'b1;
               next_state   = S_RS_E;
            end
         end
         S_RS_E:
         begin
            if (baud_timeout)
            begin
               next_scl_low = 1'b1;
               req_done     = 1'b1;
               set_irq      = 1'b1;
               brg_halt     = 1'b1;
               next_state   = S_IDLE;
            end
         end
         S_AK_A:
         begin
            if (baud_timeout)
            begin
               next_scl_low = 1'b0;
               brg_halt     = 1'b1;
               next_state   = S_AK_B;
            end
         end
         S_AK_B:
         begin
            if (sync2.scl)
            begin
               brg_load   = 1'b1;
               next_state = S_AK_C;
            end
         end
         S_AK_C:
         begin
            if (baud_timeout)
            begin
               next_scl_low = 1'b1;
               req_done     = 1'b1;
               set_irq      = 1'b1;
               brg_halt     = 1'b1;
               next_state   = S_IDLE;
            end
         end
         S_SP_A:
         begin
            if (!sync2.sda)
            begin
               brg_load   = 1'b1;
               next_state = S_SP_B;
            end
         end
         S_SP_B:
         begin
            if (baud_timeout)
            begin
               next_scl_low = 1'b0;
               brg_halt     = 1'b1;
               next_state   = S_SP_C;
            end
         end
         S_SP_C:
         begin
            if (sync2.scl)
            begin
               brg_load   = 1'b1;
               next_state = S_SP_D;
            end
         end
         S_SP_D:
         begin
            if (baud_timeout)
            begin
               next_sda_low = 1'b0;
               brg_halt     = 1'b1;
               next_state   = S_SP_E;
            end
         end
         S_SP_E:
         begin
            if (sync2.sda && sync2.scl)
            begin
               set_stop_flag = 1'b1;
               brg_load      = 1'b1;
               next_state    = S_SP_F;
            end
         end
         S_SP_F:
         begin
            if (baud_timeout)
            begin
               req_done   = 1'b1;
               set_irq    = 1'b1;
               brg_halt   = 1'b1;
               next_state = S_IDLE;
            end
         end
         default:
         begin
            next_state = S_IDLE;
         end
      endcase
   end

   // Sequencer state and line drive
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state       <= S_IDLE;
         drv_sda_low <= 1'b0;
         drv_scl_low <= 1'b0;
      end
      else if (host_active)
      begin
         state       <= next_state;
         drv_sda_low <= next_sda_low;
         drv_scl_low <= next_scl_low;
      end
      else
      begin
         state       <= S_IDLE;
         drv_sda_low <= fw_active && sw_sda_low;
         drv_scl_low <= fw_active && sw_scl_low;
      end
   end

   // Open-drain pins only ever pull low
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         line_oe  <= '0;
         line_out <= '0;
      end
      else
      begin
         line_oe  <= '{sda: drv_sda_low, scl: drv_scl_low};
         line_out <= '0;
      end
   end

   // Baud counter: reload, count down to zero, halt
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         baud_counter <= '0;
         baud_run     <= 1'b0;
      end
      else if (!host_active || brg_halt)
      begin
         baud_run <= 1'b0;
      end
      else if (brg_load)
      begin
         baud_counter <= baud_divisor_reg;
         baud_run     <= 1'b1;
      end
      else if (baud_run && baud_counter != '0)
      begin
         baud_counter <= baud_counter - 1'b1;
      end
   end

   // Control, divisor and request registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port_enable_bit  <= 1'b0;
         port_mode_select <= MODE_OFF;
         sw_sda_low       <= 1'b0;
         sw_scl_low       <= 1'b0;
         baud_divisor_reg <= DIV_RESET;
         ack_value_bit    <= 1'b0;
         seq_req          <= '0;
      end
      else
      begin
         if (wr_done && paddr == OFS_CTRL)
         begin
            port_enable_bit  <= pwdata[CTRL_ENABLE];
            port_mode_select <= pwdata[CTRL_MODE_LSB +: 2];
            sw_sda_low       <= pwdata[CTRL_SW_SDA];
            sw_scl_low       <= pwdata[CTRL_SW_SCL];
         end
         if (wr_done && paddr == OFS_DIV)
            baud_divisor_reg <= pwdata[DIVW-1:0];
         if (wr_done && paddr == OFS_SEQ)
            ack_value_bit <= pwdata[SEQ_ACK_VAL];
         if (!host_active || req_done)
            seq_req <= '0;
         else if (wr_done && paddr == OFS_SEQ && state == S_IDLE && seq_req == '0)
            seq_req <= {1'b0, pwdata[SEQ_ACK:0]};
      end
   end

   // Transmit buffer with write collision
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         shift_buffer <= BUF_RESET;
      else if (wr_done && paddr == OFS_BUF && state == S_IDLE && seq_req == '0)
         shift_buffer <= pwdata[7:0];
   end

   // Status flags: hardware set wins over software clear, except that disabling the port clears the start and stop flags first
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         start_detected       <= 1'b0;
         stop_detected        <= 1'b0;
         serial_irq_flag      <= 1'b0;
         write_collision_flag <= 1'b0;
         bus_collision_flag   <= 1'b0;
      end
      else
      begin
         if (!port_enable_bit)
         begin
            start_detected <= 1'b0;
            stop_detected  <= 1'b0;
         end
         else if (set_start_flag || det_start)
         begin
            start_detected <= 1'b1;
            stop_detected  <= 1'b0;
         end
         else if (set_stop_flag || det_stop)
         begin
            stop_detected  <= 1'b1;
            start_detected <= 1'b0;
         end
         // A restart's own start condition waits for the counter timeout
         if (set_irq || ((det_start || det_stop) && !(state inside {S_RS_D, S_RS_E})))
            serial_irq_flag <= 1'b1;
         else if (wr_done && paddr == OFS_STATUS && pwdata[ST_IRQ])
            serial_irq_flag <= 1'b0;
         if (wr_done && paddr == OFS_BUF && (state != S_IDLE || seq_req != '0))
            write_collision_flag <= 1'b1;
         else if (wr_done && paddr == OFS_STATUS && pwdata[ST_WRITE_COLLISION_FLAG])
            write_collision_flag <= 1'b0;
         if (set_bcol)
            bus_collision_flag <= 1'b1;
         else if (wr_done && paddr == OFS_STATUS && pwdata[ST_BCOL])
            bus_collision_flag <= 1'b0;
      end
   end

   // Read mux
   always_comb
   begin
      rd_word = '0;
      case (paddr)
         OFS_CTRL:
         begin
            rd_word[CTRL_ENABLE]            = port_enable_bit;
            rd_word[CTRL_MODE_LSB +: 2]     = port_mode_select;
            rd_word[CTRL_SW_SDA]            = sw_sda_low;
            rd_word[CTRL_SW_SCL]            = sw_scl_low;
         end
         OFS_SEQ:
         begin
            rd_word[SEQ_REQ_W-1:0] = seq_req;
            rd_word[SEQ_ACK_VAL]   = ack_value_bit;
         end
         OFS_STATUS:
         begin
            rd_word[ST_START_DET] = start_detected;
            rd_word[ST_STOP_DET]  = stop_detected;
            rd_word[ST_IRQ]       = serial_irq_flag;
            rd_word[ST_WRITE_COLLISION_FLAG]      = write_collision_flag;
            rd_word[ST_BCOL]      = bus_collision_flag;
            rd_word[ST_BUSY]      = (state != S_IDLE) || (seq_req != '0);
            rd_word[ST_BUS_CLAIM] = start_detected && !stop_detected;
         end
         OFS_DIV:
            rd_word[DIVW-1:0] = baud_divisor_reg;
         OFS_BUF:
            rd_word[7:0] = shift_buffer;
         default:
            rd_word = '0;
      endcase
   end

   // APB answer one cycle into the access phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end
      else
      begin
         pready  <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !mapped;
         if (psel && penable && !pready)
            prdata <= rd_word;
      end
   end

endmodule : ihbs_sequencer

`default_nettype wire

// ---- ihbs_sequencer_bench.sv ----
// Self-checking bench for the I2C host sequencer
`timescale 1ns/1ps
`default_nettype none
module ihbs_sequencer_bench;
   import ihbs_pkg::*;
   logic              pclk = 1'b0;
   logic              presetn = 1'b0;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic [4:0]        paddr = 5'h0;
   logic [31:0]       pwdata = 32'h0;
   logic [31:0]       prdata;
   logic [31:0]       rd_val;
   logic              pready;
   logic              pslverr;
   logic              rd_err;
   logic              irq;
   ihbs_line_t        lin;
   ihbs_line_t        lout;
   ihbs_line_t        loe;
   logic [3:0]        stretch = 4'h0;
   logic              jam = 1'b0;
   int                errors = 0;
   int                n_tests = 0;
   always #20 pclk = ~pclk;
   ihbs_sequencer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_in(lin),
      .line_out(lout), .line_oe(loe), .serial_irq_flag(irq));
   ihbs_client_model bus (.pclk(pclk), .presetn(presetn), .line_oe(loe), .stretch(stretch), .jam(jam),
      .line_in(lin));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      rd_val = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20)
         check(32'h0, 32'h1);
   endtask : apb
   task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd_val & m, exp);
   endtask : rd
   task automatic wait_idle;
      int i;
      rd_val = '1;
      for (i = 0; i < 300 && rd_val[ST_BUSY] !== 1'b0; i++)
         apb(1'b0, OFS_STATUS, 32'h0);
      check({31'h0, rd_val[ST_BUSY]}, 32'h0);
   endtask : wait_idle
   task automatic end_sim;
      $display("Comparisons %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_sim
   initial
   begin
      #2000000;
      errors++;
      end_sim();
   end
   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(OFS_DIV, 32'hff, {24'h0, DIV_RESET});
      rd(OFS_STATUS, 32'hff, 32'h0);
      apb(1'b0, 5'h14, 32'h0);
      check({rd_val[30:0], rd_err}, 32'h1);
      apb(1'b1, 5'h02, 32'h0);
      check({31'h0, rd_err}, 32'h1);
      apb(1'b1, OFS_DIV, 32'h3);
      apb(1'b1, OFS_CTRL, 32'h3);
      apb(1'b1, OFS_SEQ, 32'h1);
      apb(1'b1, OFS_BUF, 32'ha5);
      apb(1'b1, OFS_SEQ, 32'h4);
      wait_idle();
      check({30'h0, loe}, 32'h2);
      rd(OFS_STATUS, 32'hff, 32'h4d);
      check({31'h0, irq}, 32'h1);
      rd(OFS_BUF, 32'hff, {24'h0, BUF_RESET});
      apb(1'b1, OFS_STATUS, 32'h1c);
      rd(OFS_STATUS, 32'hff, 32'h41);
      stretch <= 4'h6;
      apb(1'b1, OFS_SEQ, 32'h28);
      apb(1'b1, OFS_BUF, 32'h5a);
      wait_idle();
      check({30'h0, loe}, 32'h1);
      rd(OFS_STATUS, 32'h1c, 32'h0c);
      apb(1'b1, OFS_STATUS, 32'h1c);
      apb(1'b1, OFS_SEQ, 32'h2);
      wait_idle();
      check({30'h0, loe}, 32'h3);
      rd(OFS_STATUS, 32'h45, 32'h45);
      apb(1'b1, OFS_STATUS, 32'h1c);
      apb(1'b1, OFS_SEQ, 32'h4);
      wait_idle();
      check({30'h0, loe}, 32'h0);
      rd(OFS_STATUS, 32'h46, 32'h06);
      apb(1'b1, OFS_CTRL, 32'h0);
      rd(OFS_STATUS, 32'h3, 32'h0);
      apb(1'b1, OFS_CTRL, 32'h3);
      jam <= 1'b1;
      apb(1'b1, OFS_SEQ, 32'h1);
      wait_idle();
      rd(OFS_STATUS, 32'h11, 32'h10);
      check({30'h0, loe}, 32'h0);
      jam <= 1'b0;
      apb(1'b1, OFS_CTRL, 32'h0);
      apb(1'b1, OFS_CTRL, 32'h0d);
      // Line change needs the pull, two sync stages and the edge stage
      repeat (4) @(posedge pclk);
      rd(OFS_STATUS, 32'h3, 32'h1);
      apb(1'b1, OFS_SEQ, 32'h4);
      rd(OFS_SEQ, 32'h1f, 32'h0);
      apb(1'b1, OFS_CTRL, 32'h05);
      repeat (4) @(posedge pclk);
      rd(OFS_STATUS, 32'h2, 32'h2);
      end_sim();
   end
endmodule : ihbs_sequencer_bench
`default_nettype wire
